// ===== rtl/cpu_core_pkg.sv
package cpu_core_pkg;

  // Status flag bit positions.
  localparam int FLAG_N = 7;
  localparam int FLAG_V = 6;
  localparam int FLAG_T = 5;
  localparam int FLAG_B = 4;
  localparam int FLAG_D = 3;
  localparam int FLAG_I = 2;
  localparam int FLAG_Z = 1;
  localparam int FLAG_C = 0;

  localparam logic [7:0]  STATUS_RESET   = 8'h04;
  localparam logic [7:0]  STACK_RESET    = 8'hff;
  localparam logic [7:0]  STACK_PAGE     = 8'h01;
  localparam logic [7:0]  ZERO_PAGE      = 8'h00;
  localparam logic [15:0] RESET_VEC_ADDR = 16'hfffe;
  localparam logic [15:0] IRQ_VEC_ADDR   = 16'hfff4;
  localparam logic [15:0] IRQ_REQ_ADDR   = 16'h003c;
  localparam logic [15:0] IRQ_EN_ADDR    = 16'h003d;
  localparam int          IRQ_BITS       = 4;

  localparam logic [4:0]  BCD_MAX_DIGIT  = 5'h09;
  localparam logic [4:0]  BCD_ADJUST     = 5'h06;

  // Opcodes handled by this core.
  localparam logic [7:0] OP_STORE_ACCUMULATOR_ZPX  = 8'h95;
  localparam logic [7:0] OP_STORE_ACCUMULATOR_ABS  = 8'h8d;
  localparam logic [7:0] OP_STORE_ACCUMULATOR_ABSX = 8'h9d;
  localparam logic [7:0] OP_STORE_ACCUMULATOR_ABSY = 8'h99;
  localparam logic [7:0] OP_STORE_ACCUMULATOR_INDX = 8'h81;
  localparam logic [7:0] OP_STORE_ACCUMULATOR_INDY = 8'h91;
  localparam logic [7:0] OP_STORE_INDEX_X_ZPY      = 8'h96;
  localparam logic [7:0] OP_STORE_INDEX_X_ABS      = 8'h8e;
  localparam logic [7:0] OP_STORE_INDEX_Y_ZPX      = 8'h94;
  localparam logic [7:0] OP_STORE_INDEX_Y_ABS      = 8'h8c;
  localparam logic [7:0] OP_LOAD_A_IMM             = 8'ha9;
  localparam logic [7:0] OP_LOAD_X_IMM             = 8'ha2;
  localparam logic [7:0] OP_LOAD_Y_IMM             = 8'ha0;
  localparam logic [7:0] OP_LOAD_A_ABS             = 8'had;
  localparam logic [7:0] OP_ADD_WITH_CARRY_IMM     = 8'h69;
  localparam logic [7:0] OP_SUBTRACT_WITH_BORROW   = 8'he9;
  localparam logic [7:0] OP_SET_CARRY_FLAG         = 8'h38;
  localparam logic [7:0] OP_CLEAR_CARRY_FLAG       = 8'h18;
  localparam logic [7:0] OP_SET_DECIMAL_FLAG       = 8'hf8;
  localparam logic [7:0] OP_CLEAR_DECIMAL_FLAG     = 8'hd8;
  localparam logic [7:0] OP_SET_INT_DISABLE        = 8'h78;
  localparam logic [7:0] OP_CLEAR_INT_DISABLE      = 8'h58;
  localparam logic [7:0] OP_PUSH_STATUS            = 8'h08;
  localparam logic [7:0] OP_PULL_STATUS            = 8'h28;
  localparam logic [7:0] OP_SOFTWARE_BREAK         = 8'h00;

  // Instruction lengths in clock cycles.
  localparam logic [3:0] CYC_ZP_INDEXED  = 4'h5;
  localparam logic [3:0] CYC_ABSOLUTE    = 4'h5;
  localparam logic [3:0] CYC_ABS_INDEXED = 4'h6;
  localparam logic [3:0] CYC_INDIRECT    = 4'h7;
  localparam logic [3:0] CYC_IMPLIED     = 4'h2;
  localparam logic [3:0] CYC_IMMEDIATE   = 4'h2;
  localparam logic [3:0] CYC_PUSH_STATUS = 4'h3;
  localparam logic [3:0] CYC_PULL_STATUS = 4'h4;
  localparam logic [3:0] CYC_LOAD_ABS    = 4'h4;
  localparam logic [3:0] CYC_BREAK       = 4'h6;

  typedef enum logic [2:0] {
    CLS_STORE, CLS_IMM, CLS_LOAD_ABS, CLS_IMPL,
    CLS_PUSH_P, CLS_PULL_P, CLS_BREAK
  } op_class_t;

  typedef enum logic [2:0] {
    MODE_NONE, MODE_ZPX, MODE_ZPY, MODE_ABS,
    MODE_ABSX, MODE_ABSY, MODE_INDX, MODE_INDY
  } addr_mode_t;

  typedef enum logic [1:0] {SRC_NONE, SRC_A, SRC_X, SRC_Y} src_t;

  typedef enum logic [3:0] {
    S_OPC, S_OP1, S_OP2, S_PTR_LO, S_PTR_HI, S_WRITE, S_READ,
    S_PULL, S_PUSH_H, S_PUSH_L, S_PUSH_P, S_VEC_LO, S_VEC_HI, S_WAIT
  } state_t;

  typedef enum logic [1:0] {PEND_IDLE, PEND_WRITTEN, PEND_AGED} pend_t;

  typedef struct packed {
    op_class_t  cls;
    addr_mode_t mode;
    src_t       src;
    logic [3:0] len;
  } dec_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        we;
  } mem_req_t;

  typedef struct packed {
    logic [7:0] res;
    logic       c;
    logic       v;
    logic       n;
    logic       z;
  } alu_out_t;

  function automatic dec_t decode(input logic [7:0] op);
    dec_t d;
    d = '{cls: CLS_IMPL, mode: MODE_NONE, src: SRC_NONE, len: CYC_IMPLIED};
    case (op)
      OP_STORE_ACCUMULATOR_ZPX:  d = '{CLS_STORE, MODE_ZPX, SRC_A, CYC_ZP_INDEXED};
      OP_STORE_ACCUMULATOR_ABS:  d = '{CLS_STORE, MODE_ABS, SRC_A, CYC_ABSOLUTE};
      OP_STORE_ACCUMULATOR_ABSX: d = '{CLS_STORE, MODE_ABSX, SRC_A, CYC_ABS_INDEXED};
      OP_STORE_ACCUMULATOR_ABSY: d = '{CLS_STORE, MODE_ABSY, SRC_A, CYC_ABS_INDEXED};
      OP_STORE_ACCUMULATOR_INDX: d = '{CLS_STORE, MODE_INDX, SRC_A, CYC_INDIRECT};
      OP_STORE_ACCUMULATOR_INDY: d = '{CLS_STORE, MODE_INDY, SRC_A, CYC_INDIRECT};
      OP_STORE_INDEX_X_ZPY:      d = '{CLS_STORE, MODE_ZPY, SRC_X, CYC_ZP_INDEXED};
      OP_STORE_INDEX_X_ABS:      d = '{CLS_STORE, MODE_ABS, SRC_X, CYC_ABSOLUTE};
      OP_STORE_INDEX_Y_ZPX:      d = '{CLS_STORE, MODE_ZPX, SRC_Y, CYC_ZP_INDEXED};
      OP_STORE_INDEX_Y_ABS:      d = '{CLS_STORE, MODE_ABS, SRC_Y, CYC_ABSOLUTE};
      OP_LOAD_A_IMM, OP_LOAD_X_IMM, OP_LOAD_Y_IMM,
      OP_ADD_WITH_CARRY_IMM, OP_SUBTRACT_WITH_BORROW:
        d = '{CLS_IMM, MODE_NONE, SRC_NONE, CYC_IMMEDIATE};
      OP_LOAD_A_ABS:     d = '{CLS_LOAD_ABS, MODE_ABS, SRC_NONE, CYC_LOAD_ABS};
      OP_PUSH_STATUS:    d = '{CLS_PUSH_P, MODE_NONE, SRC_NONE, CYC_PUSH_STATUS};
      OP_PULL_STATUS:    d = '{CLS_PULL_P, MODE_NONE, SRC_NONE, CYC_PULL_STATUS};
      OP_SOFTWARE_BREAK: d = '{CLS_BREAK, MODE_NONE, SRC_NONE, CYC_BREAK};
      default:           d = d;
    endcase
    return d;
  endfunction

endpackage

// ===== rtl/bcd_binary_alu.sv
`timescale 1ns/10ps
`default_nettype none
module bcd_binary_alu
  import cpu_core_pkg::*;
(
  input  wire logic [7:0] a,
  input  wire logic [7:0] b,
  input  wire logic       carry_in,
  input  wire logic       subtract,
  input  wire logic       decimal,
  output var  alu_out_t   result
);

  always_comb begin
    logic [7:0] bb;
    logic [8:0] bin;
    logic [4:0] lo;
    logic [4:0] hi;
    logic       lc;
    bb  = subtract ? ~b : b;
    bin = {1'b0, a} + {1'b0, bb} + {8'h00, carry_in};
    lo  = 5'h00;
    hi  = 5'h00;
    lc  = 1'b0;
    // In decimal mode these three come from the binary sum and are not
    // meaningful; software must not test them.
    result.n = bin[7];
    result.z = (bin[7:0] == 8'h00);
    result.v = (a[7] == bb[7]) && (bin[7] != a[7]);
    result.res = bin[7:0];
    result.c   = bin[8];
    if (decimal && !subtract) begin
      lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, carry_in};
      lc = (lo > BCD_MAX_DIGIT);
      if (lc) begin
        lo = lo + BCD_ADJUST;
      end
      hi = {1'b0, a[7:4]} + {1'b0, b[7:4]} + {4'h0, lc};
      result.c = (hi > BCD_MAX_DIGIT);
      if (result.c) begin
        hi = hi + BCD_ADJUST;
      end
      result.res = {hi[3:0], lo[3:0]};
    end else if (decimal) begin
      lo = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, ~carry_in};
      lc = lo[4];
      if (lc) begin
        lo = lo - BCD_ADJUST;
      end
      hi = {1'b0, a[7:4]} - {1'b0, b[7:4]} - {4'h0, lc};
      result.c = ~hi[4];
      if (hi[4]) begin
        hi = hi - BCD_ADJUST;
      end
      result.res = {hi[3:0], lo[3:0]};
    end
  end

endmodule
`default_nettype wire

// ===== rtl/cpu_status_store_core.sv
// Summary of operation
// - Reset sets interrupt disable to one; the other flags are cleared to zero.
// - Status bits: 7 negative, 6 overflow, 5 index-arith, 4 break, 3 decimal.
// - Store accumulator in six modes with fixed cycles and bytes, no flags.
// - Store index X in zero-page-Y and absolute modes, fixed cycle counts.
// - Store index Y in zero-page-X and absolute modes, flags untouched.
// - A written interrupt request bit is not seen by the next instruction.
// - Enable takes effect before request clear, so a pending request is taken.
// - Break with enabled pending request and disable set cancels the disable.
// - Break flag in the stacked status tells break from the shared interrupt.
// - Only add and subtract with carry perform decimal adjustment.
// - Negative, overflow and zero are invalid after decimal arithmetic.
// - Decimal carry is one on carry out, zero on borrow.
// - Pushed status sits at stack pointer plus one; pulling restores it.
// - Push status writes at the stack pointer, then decrements it by one.
// - Set decimal, two cycles, sets only the decimal flag.
`timescale 1ns/10ps
`default_nettype none
module cpu_status_store_core
  import cpu_core_pkg::*;
(
  input  wire logic                clk,
  input  wire logic                nrst,
  input  wire logic [IRQ_BITS-1:0] irq_pin,
  input  wire logic [7:0]          mem_rdata,
  output var  mem_req_t            mem_req,
  output var  logic [7:0]          status_flags,
  output var  logic                opcode_fetch
);

  state_t              state_reg;
  state_t              state_next;
  logic [3:0]          cnt_reg;
  logic [7:0]          opc_reg;
  logic [7:0]          op1_reg;
  logic [7:0]          lo_reg;
  logic [7:0]          ptr_reg;
  logic [7:0]          a_reg;
  logic [7:0]          x_reg;
  logic [7:0]          y_reg;
  logic [7:0]          s_reg;
  logic [7:0]          p_reg;
  logic [15:0]         pc_reg;
  logic [15:0]         pc_next;
  logic [15:0]         vec_reg;
  logic                entry_reg;
  logic                brk_reg;
  mem_req_t            req_next;
  logic [IRQ_BITS-1:0] irq_meta_reg;
  logic [IRQ_BITS-1:0] irq_sync_reg;
  logic [IRQ_BITS-1:0] irq_prev_reg;
  logic [IRQ_BITS-1:0] req_reg;
  logic [IRQ_BITS-1:0] en_reg;
  logic [IRQ_BITS-1:0] pend_reg;
  pend_t               pend_stage_reg;
  logic [IRQ_BITS-1:0] ready_irq;
  logic [IRQ_BITS-1:0] set_ev;
  logic [IRQ_BITS-1:0] take_clr;
  dec_t                dec;
  logic [7:0]          rd;
  logic [7:0]          idx;
  logic [7:0]          src_val;
  logic [7:0]          ptr;
  logic [15:0]         ea_abs;
  logic [15:0]         ea_ind;
  logic                last;
  logic                boundary;
  logic                take_int;
  alu_out_t            alu;

  function automatic logic [15:0] stack_addr(input logic [7:0] sp);
    return {STACK_PAGE, sp};
  endfunction

  function automatic logic [7:0] with_nz(input logic [7:0] p,
                                         input logic [7:0] v);
    logic [7:0] r;
    r = p;
    r[FLAG_N] = v[7];
    r[FLAG_Z] = (v == 8'h00);
    return r;
  endfunction

  // Interrupt request and enable bits are visible at their own addresses.
  function automatic logic [7:0] read_byte(input logic [15:0] addr,
                                           input logic [7:0]  mem,
                                           input logic [IRQ_BITS-1:0] rq,
                                           input logic [IRQ_BITS-1:0] en);
    if (addr == IRQ_REQ_ADDR) begin
      return {{(8 - IRQ_BITS){1'b0}}, rq};
    end else if (addr == IRQ_EN_ADDR) begin
      return {{(8 - IRQ_BITS){1'b0}}, en};
    end
    return mem;
  endfunction

  assign status_flags = p_reg;
  assign rd        = read_byte(mem_req.addr, mem_rdata, req_reg, en_reg);
  assign dec       = decode((state_reg == S_OPC) ? rd : opc_reg);
  assign last      = (cnt_reg == dec.len - 4'h1);
  assign boundary  = !entry_reg && last;
  assign ready_irq = req_reg & en_reg;
  assign take_int  = (|ready_irq) && !p_reg[FLAG_I];
  assign set_ev    = irq_sync_reg & ~irq_prev_reg;
  assign take_clr  = (boundary && take_int) ?
                     (ready_irq & (~ready_irq + IRQ_BITS'(1))) : '0;

  always_comb begin
    unique case (dec.mode)
      MODE_ZPX, MODE_ABSX: idx = x_reg;
      MODE_ZPY, MODE_ABSY: idx = y_reg;
      default:             idx = 8'h00;
    endcase
    unique case (dec.src)
      SRC_X:   src_val = x_reg;
      SRC_Y:   src_val = y_reg;
      default: src_val = a_reg;
    endcase
    ptr    = (dec.mode == MODE_INDX) ? rd + x_reg : rd;
    ea_abs = {rd, op1_reg} + {8'h00, idx};
    ea_ind = {rd, lo_reg} + {8'h00, (dec.mode == MODE_INDY) ? y_reg : 8'h00};
  end

  bcd_binary_alu u_alu (
    .a        (a_reg),
    .b        (rd),
    .carry_in (p_reg[FLAG_C]),
    .subtract (opc_reg == OP_SUBTRACT_WITH_BORROW),
    .decimal  (p_reg[FLAG_D]),
    .result   (alu)
  );

  // Bus sequencer: each state's address is registered one cycle ahead.
  always_comb begin
    state_next = state_reg;
    pc_next    = pc_reg;
    req_next   = '{addr: mem_req.addr, wdata: 8'h00, we: 1'b0};
    unique case (state_reg)
      S_OPC: begin
        pc_next = pc_reg + 16'h0001;
        unique case (dec.cls)
          CLS_STORE, CLS_IMM, CLS_LOAD_ABS: begin
            state_next    = S_OP1;
            req_next.addr = pc_reg + 16'h0001;
          end
          CLS_PUSH_P: begin
            state_next = S_PUSH_P;
            req_next   = '{stack_addr(s_reg), p_reg, 1'b1};
          end
          CLS_PULL_P: begin
            state_next    = S_PULL;
            req_next.addr = stack_addr(s_reg + 8'h01);
          end
          CLS_BREAK: begin
            // The byte after the break opcode is skipped on return.
            pc_next    = pc_reg + 16'h0002;
            state_next = S_PUSH_H;
            req_next   = '{stack_addr(s_reg), pc_next[15:8], 1'b1};
          end
          default: state_next = S_WAIT;
        endcase
      end
      S_OP1: begin
        pc_next = pc_reg + 16'h0001;
        unique case (dec.mode)
          MODE_ABS, MODE_ABSX, MODE_ABSY: begin
            state_next    = S_OP2;
            req_next.addr = pc_reg + 16'h0001;
          end
          MODE_INDX, MODE_INDY: begin
            state_next    = S_PTR_LO;
            req_next.addr = {ZERO_PAGE, ptr};
          end
          MODE_ZPX, MODE_ZPY: begin
            state_next = S_WRITE;
            req_next   = '{{ZERO_PAGE, rd + idx}, src_val, 1'b1};
          end
          default: state_next = S_WAIT;
        endcase
      end
      S_OP2: begin
        pc_next = pc_reg + 16'h0001;
        if (dec.cls == CLS_STORE) begin
          state_next = S_WRITE;
          req_next   = '{ea_abs, src_val, 1'b1};
        end else begin
          state_next    = S_READ;
          req_next.addr = ea_abs;
        end
      end
      S_PTR_LO: begin
        state_next    = S_PTR_HI;
        req_next.addr = {ZERO_PAGE, ptr_reg + 8'h01};
      end
      S_PTR_HI: begin
        state_next = S_WRITE;
        req_next   = '{ea_ind, src_val, 1'b1};
      end
      S_WRITE, S_READ, S_PULL: state_next = S_WAIT;
      S_PUSH_H: begin
        state_next = S_PUSH_L;
        req_next   = '{stack_addr(s_reg - 8'h01), pc_reg[7:0], 1'b1};
      end
      S_PUSH_L: begin
        state_next = S_PUSH_P;
        req_next   = '{stack_addr(s_reg - 8'h01), p_reg, 1'b1};
        req_next.wdata[FLAG_B] = brk_reg;
      end
      S_PUSH_P: begin
        state_next    = entry_reg ? S_VEC_LO : S_WAIT;
        req_next.addr = vec_reg;
      end
      S_VEC_LO: begin
        state_next    = S_VEC_HI;
        req_next.addr = vec_reg + 16'h0001;
      end
      S_VEC_HI: begin
        state_next    = S_OPC;
        pc_next       = {rd, lo_reg};
        req_next.addr = pc_next;
      end
      default: state_next = S_WAIT;
    endcase
    if (boundary) begin
      if (take_int) begin
        state_next = S_PUSH_H;
        req_next   = '{stack_addr(s_reg), pc_next[15:8], 1'b1};
      end else begin
        state_next = S_OPC;
        req_next   = '{pc_next, 8'h00, 1'b0};
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_reg    <= S_VEC_LO;
      cnt_reg      <= 4'h0;
      pc_reg       <= RESET_VEC_ADDR;
      mem_req      <= '{RESET_VEC_ADDR, 8'h00, 1'b0};
      opcode_fetch <= 1'b0;
    end else begin
      state_reg    <= state_next;
      cnt_reg      <= (state_next == S_OPC) ? 4'h0 : cnt_reg + 4'h1;
      pc_reg       <= pc_next;
      mem_req      <= req_next;
      opcode_fetch <= (state_next == S_OPC);
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      opc_reg <= 8'h00;
      op1_reg <= 8'h00;
      ptr_reg <= 8'h00;
      lo_reg  <= 8'h00;
    end else begin
      if (state_reg == S_OPC) begin
        opc_reg <= rd;
      end
      if (state_reg == S_OP1) begin
        op1_reg <= rd;
        ptr_reg <= ptr;
      end
      if (state_reg == S_PTR_LO || state_reg == S_VEC_LO) begin
        lo_reg <= rd;
      end
    end
  end

  // Exception entry: reset starts inside the vector fetch.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      entry_reg <= 1'b1;
      brk_reg   <= 1'b0;
      vec_reg   <= RESET_VEC_ADDR;
    end else if (state_next == S_PUSH_H && state_reg != S_PUSH_H) begin
      entry_reg <= 1'b1;
      brk_reg   <= !boundary;
      vec_reg   <= IRQ_VEC_ADDR;
    end else if (state_reg == S_VEC_HI) begin
      entry_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      a_reg <= 8'h00;
      x_reg <= 8'h00;
      y_reg <= 8'h00;
    end else if (state_reg == S_OP1 && dec.cls == CLS_IMM) begin
      unique case (opc_reg)
        OP_LOAD_A_IMM: a_reg <= rd;
        OP_LOAD_X_IMM: x_reg <= rd;
        OP_LOAD_Y_IMM: y_reg <= rd;
        default:       a_reg <= alu.res;
      endcase
    end else if (state_reg == S_READ) begin
      a_reg <= rd;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_reg <= STACK_RESET;
    end else if (state_reg == S_PUSH_H || state_reg == S_PUSH_L ||
                 state_reg == S_PUSH_P) begin
      s_reg <= s_reg - 8'h01;
    end else if (state_reg == S_OPC && dec.cls == CLS_PULL_P) begin
      s_reg <= s_reg + 8'h01;
    end
  end

  // No branch of this block matches a store, so stores leave every flag alone.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      p_reg <= STATUS_RESET;
    end else begin
      unique case (state_reg)
        S_OPC: begin
          unique case (rd)
            OP_SET_CARRY_FLAG:     p_reg[FLAG_C] <= 1'b1;
            OP_CLEAR_CARRY_FLAG:   p_reg[FLAG_C] <= 1'b0;
            OP_SET_DECIMAL_FLAG:   p_reg[FLAG_D] <= 1'b1;
            OP_CLEAR_DECIMAL_FLAG: p_reg[FLAG_D] <= 1'b0;
            OP_SET_INT_DISABLE:    p_reg[FLAG_I] <= 1'b1;
            OP_CLEAR_INT_DISABLE:  p_reg[FLAG_I] <= 1'b0;
            default:               p_reg <= p_reg;
          endcase
        end
        S_OP1: begin
          if (opc_reg == OP_ADD_WITH_CARRY_IMM ||
              opc_reg == OP_SUBTRACT_WITH_BORROW) begin
            p_reg[FLAG_N] <= alu.n;
            p_reg[FLAG_V] <= alu.v;
            p_reg[FLAG_Z] <= alu.z;
            p_reg[FLAG_C] <= alu.c;
          end else if (dec.cls == CLS_IMM) begin
            p_reg <= with_nz(p_reg, rd);
          end
        end
        S_READ: p_reg <= with_nz(p_reg, rd);
        S_PULL: p_reg <= rd;
        S_PUSH_P: begin
          // A break with an enabled request pending leaves interrupts open.
          if (entry_reg) begin
            p_reg[FLAG_I] <= !(brk_reg && (|ready_irq));
          end
        end
        default: p_reg <= p_reg;
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irq_meta_reg <= '0;
      irq_sync_reg <= '0;
      irq_prev_reg <= '0;
    end else begin
      irq_meta_reg <= irq_pin;
      irq_sync_reg <= irq_meta_reg;
      irq_prev_reg <= irq_sync_reg;
    end
  end

  // Enable writes land at once while request writes wait, so a combined
  // update still lets the old request through.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      en_reg <= '0;
    end else if (state_reg == S_WRITE && mem_req.addr == IRQ_EN_ADDR) begin
      en_reg <= mem_req.wdata[IRQ_BITS-1:0];
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pend_reg       <= '0;
      pend_stage_reg <= PEND_IDLE;
    end else if (state_reg == S_WRITE && mem_req.addr == IRQ_REQ_ADDR) begin
      pend_reg       <= mem_req.wdata[IRQ_BITS-1:0];
      pend_stage_reg <= PEND_WRITTEN;
    end else if (boundary && pend_stage_reg == PEND_WRITTEN) begin
      pend_stage_reg <= PEND_AGED;
    end else if (boundary && pend_stage_reg == PEND_AGED) begin
      pend_stage_reg <= PEND_IDLE;
    end
  end

  // Pin events win over both the delayed write and the acceptance clear.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      req_reg <= '0;
    end else if (boundary && pend_stage_reg == PEND_AGED) begin
      req_reg <= pend_reg | set_ev;
    end else begin
      req_reg <= (req_reg & ~take_clr) | set_ev;
    end
  end

endmodule
`default_nettype wire

// ===== tb/cpu_status_store_checker.sv
`timescale 1ns/10ps
`default_nettype none
module cpu_status_store_checker
  import cpu_core_pkg::*;
(
  input wire logic                clk,
  input wire logic                nrst,
  input wire logic [IRQ_BITS-1:0] irq_pin,
  input wire logic [7:0]          mem_rdata,
  input wire mem_req_t            mem_req,
  input wire logic [7:0]          status_flags,
  input wire logic                opcode_fetch
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  logic fz;
  logic fa;
  logic fi;
  assign fz = opcode_fetch && mem_rdata inside {8'h95, 8'h96, 8'h94};
  assign fa = opcode_fetch && mem_rdata inside {8'h8d, 8'h8e, 8'h8c};
  assign fi = opcode_fetch && mem_rdata inside {8'h81, 8'h91};
  sequence s_op(logic [7:0] o);
    opcode_fetch && mem_rdata == o;
  endsequence
  sequence s_stack_wr;
    mem_req.we && mem_req.addr[15:8] == STACK_PAGE;
  endsequence
  property p_rst;
    $rose(nrst) |-> status_flags[FLAG_I];
  endproperty
  property p_pulse;
    opcode_fetch |=> !opcode_fetch;
  endproperty
  property p_abs;
    fa |-> ##3 mem_req.we ##1 !mem_req.we ##1 opcode_fetch;
  endproperty
  property p_zp;
    fz |-> ##2 (mem_req.we && mem_req.addr[15:8] == ZERO_PAGE)
      ##3 opcode_fetch;
  endproperty
  property p_ind;
    fi |=> !opcode_fetch [*6] ##1 opcode_fetch;
  endproperty
  property p_keep;
    (fa || fz || fi) |=> ##1 $stable(status_flags) [*4];
  endproperty
  property p_push;
    s_op(OP_PUSH_STATUS) |=> s_stack_wr ##0 mem_req.wdata == status_flags
      ##2 opcode_fetch;
  endproperty
  property p_sed;
    s_op(OP_SET_DECIMAL_FLAG) |-> ##2 opcode_fetch
      && status_flags == ($past(status_flags, 2) | 8'h08);
  endproperty
  property p_brk;
    s_op(OP_SOFTWARE_BREAK) |-> ##3 s_stack_wr ##0 mem_req.wdata[FLAG_B]
      ##1 mem_req.addr == IRQ_VEC_ADDR;
  endproperty
  property p_pull;
    s_op(OP_PULL_STATUS) |=> mem_req.addr[15:8] == STACK_PAGE
      ##3 opcode_fetch;
  endproperty
  a_rst: assert property (p_rst) else $error("I not set");
  a_pulse: assert property (p_pulse) else $error("fetch wide");
  a_abs: assert property (p_abs) else $error("abs store");
  a_zp: assert property (p_zp) else $error("zp store");
  a_ind: assert property (p_ind) else $error("ind length");
  a_keep: assert property (p_keep) else $error("flags moved");
  a_push: assert property (p_push) else $error("push");
  a_sed: assert property (p_sed) else $error("set decimal");
  a_brk: assert property (p_brk) else $error("break");
  a_pull: assert property (p_pull) else $error("pull");
endmodule
`default_nettype wire

// ===== tb/bus_memory_model.sv
`timescale 1ns/10ps
`default_nettype none
module bus_memory_model
  import cpu_core_pkg::*;
(
  input  wire logic       clk,
  input  wire mem_req_t   mem_req,
  output wire logic [7:0] mem_rdata
);
  logic [7:0] ram [65536];
  // Unloaded cells hold a filler opcode so a stray fetch cannot hang.
  initial for (int i = 0; i < 65536; i++) ram[i] = 8'hea;
  assign mem_rdata = ram[mem_req.addr];
  always @(posedge clk) if (mem_req.we) ram[mem_req.addr] <= mem_req.wdata;
endmodule
`default_nettype wire

// ===== tb/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
  import cpu_core_pkg::*;
  localparam int PLEN = 69;
  localparam logic [8*PLEN-1:0] PROG = {64'ha9aaa205a0038d00,
    64'h039d000399000395, 64'h108120913096408e, 64'h100394508c110318,
    64'hf8a9196928ea8d12, 64'h03a9506960ea8d13,
    64'h030838a920e905ea, 64'ha905e910ea8d1403,
    40'h08d828ea00};
  localparam logic [23:0] INIT [8] = '{24'hfffe00, 24'hffff02, 24'hfff400,
    24'hfff504, 24'h002540, 24'h002603, 24'h003050, 24'h003103};
  // Code at the shared vector: enable bit 0, write request bit 0 by
  // software, read the request word back at once, store it, then break.
  localparam logic [119:0] VPROG = 120'ha9018d3d008d3c00ad3c008d200300;
  localparam logic [31:0] EXP [17] = '{32'h0300aaff, 32'h0305aaff,
    32'h0303aaff, 32'h0015aaff, 32'h0340aaff, 32'h0353aaff, 32'h004305ff,
    32'h031005ff, 32'h005503ff, 32'h031103ff, 32'h031247ff, 32'h031310ff,
    32'h031495ff, 32'h01ff0d0d, 32'h01fe02ff, 32'h01fd46ff, 32'h01fc1c1d};
  logic                clk = 1'b0;
  logic                nrst = 1'b0;
  logic [IRQ_BITS-1:0] irq_pin = '0;
  logic [7:0]          mem_rdata;
  mem_req_t            mem_req;
  logic [7:0]          status_flags;
  logic                opcode_fetch;
  int                  miscompares = 0;
  int                  checks_done = 0;
  always #4 clk = ~clk;
  cpu_status_store_core dut (.clk(clk), .nrst(nrst), .irq_pin(irq_pin),
    .mem_rdata(mem_rdata), .mem_req(mem_req), .status_flags(status_flags),
    .opcode_fetch(opcode_fetch));
  bus_memory_model u_mem (.clk(clk), .mem_req(mem_req),
    .mem_rdata(mem_rdata));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                     input logic [7:0] m);
    checks_done++;
    if ((got & m) !== (exp & m)) begin
      miscompares++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic put(input logic [15:0] a, input logic [7:0] d);
    u_mem.ram[a] = d;
  endtask
  initial begin
    int n;
    int k;
    n = 0;
    @(posedge clk);
    #1;
    chk(status_flags, STATUS_RESET, 8'h04);
    for (int i = 0; i < PLEN; i++)
      put(16'h0200 + 16'(i), PROG[8*(PLEN-1-i) +: 8]);
    for (int i = 0; i < 8; i++) put(INIT[i][23:8], INIT[i][7:0]);
    for (int i = 0; i < 15; i++)
      put(16'h0400 + 16'(i), VPROG[8*(14-i) +: 8]);
    @(posedge clk);
    #1;
    nrst = 1'b1;
    $display("test reset done");
    // Break vectors to 0400, so its fetch marks the end of the program.
    while (n < 400 && !(opcode_fetch === 1'b1 && mem_req.addr === 16'h0400))
    begin
      @(posedge clk);
      #1;
      n++;
    end
    chk(mem_req.addr[15:8], 8'h04, 8'hff);
    for (int i = 0; i < 17; i++)
      chk(u_mem.ram[EXP[i][31:16]], EXP[i][15:8], EXP[i][7:0]);
    chk(status_flags, 8'h0c, 8'h0d);
    $display("test program done");
    // A pin request on bit 1 must show in the early read; the software
    // write of bit 0 lands only after it, then the break reopens interrupts.
    irq_pin = 4'h2;
    k = 0;
    while (n < 400 && k < 2) begin
      @(posedge clk);
      #1;
      n++;
      if (opcode_fetch === 1'b1 && mem_req.addr === 16'h0400) k++;
    end
    chk(u_mem.ram[16'h0320], 8'h02, 8'hff);
    chk(u_mem.ram[16'h01f7], 8'h02, 8'hff);
    chk(u_mem.ram[16'h01f6], 8'h08, 8'h1d);
    chk(status_flags, 8'h0c, 8'h0d);
    $display("test break with pending request done");
    if (n >= 400) begin
      miscompares++;
      $display("BAD %0t loop limit reached", $time);
    end
    summarize();
  end
  initial begin
    #20000;
    miscompares++;
    summarize();
  end
endmodule
bind cpu_status_store_core cpu_status_store_checker u_chk (.clk(clk),
  .nrst(nrst), .irq_pin(irq_pin), .mem_rdata(mem_rdata), .mem_req(mem_req),
  .status_flags(status_flags), .opcode_fetch(opcode_fetch));
`default_nettype wire
